//--- pkg/mode_cw_pkg.sv
// Constants and carrier types for the mode code Control Word flag block.
// Assumes a single 100 MHz clock and a host port with one-cycle read latency.
package mode_cw_pkg;
  localparam int unsigned CW_COUNT = 64;
  localparam int unsigned CW_AW = 6;
  localparam int unsigned BIT_IRQ_REQ = 13;
  localparam int unsigned BIT_FORCE_BUSY = 12;
  localparam int unsigned BIT_ACCESSED = 11;
  localparam int unsigned BIT_PTR_SECOND = 10;
  localparam int unsigned BIT_PP_ACK = 8;
  localparam int unsigned BIT_PP_ENABLE = 2;
  localparam logic [4:0] MC_RESET_RT = 5'h08;
  localparam logic [4:0] MC_DATA_FIRST = 5'h10;
  localparam logic [4:0] BCAST_ADDR = 5'h1f;
  localparam logic [15:0] CW_RESET = 16'h0000;
  localparam logic [15:0] HOST_WMASK = 16'h3004;

  // One completed or starting mode command from the protocol engine.
  typedef struct packed {
    logic start;
    logic done;
    logic good;
    logic busy_end;
    logic illegal;
    logic transmit;
    logic [4:0] rt_addr;
    logic [4:0] mode_code;
  } mc_event_t;

  // Answer to the protocol engine for the command being started.
  typedef struct packed {
    logic busy;
    logic send_data;
    logic use_second;
    logic pingpong;
  } mc_resp_t;

  typedef struct packed {
    logic irq;
    logic log_we;
    logic [5:0] log_index;
  } irq_out_t;
endpackage

//--- core/cw_store.sv
// Dual-use Control Word memory: one read port and one write port, shared by host and device.
// Assumes the caller arbitrates host and device access to the single write port.
module cw_store #(
  parameter int unsigned DEPTH = 64,
  parameter int unsigned AW = 6
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clear_all,
  input wire logic [AW-1:0] raddr,
  output logic [15:0] rdata,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [15:0] wdata
);
  logic [15:0] mem [DEPTH];

  initial
  begin
    if (DEPTH != (1 << AW))
    begin
      $error("cw_store depth must equal two to the address width");
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n || clear_all)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem[i] <= mode_cw_pkg::CW_RESET;
      end
    end
    else if (we)
    begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

//--- core/mode_cw_flags.sv
// Flag bits 13 to 10, 8 and 2 of the per-mode-code Control Words of a 1553 remote terminal.
// Assumes a protocol engine on mclk giving start and done pulses per mode command.
module mode_cw_flags (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic master_reset_n,
  input wire logic software_reset_cmd,
  input wire logic broadcast_irq_enable,
  input wire logic broadcast_disable,
  input wire logic pointer_toggle_hold_on_fail,
  input wire logic [5:0] host_addr,
  input wire logic [15:0] host_wdata,
  input wire logic host_wr,
  input wire logic host_rd,
  output logic [15:0] host_rdata,
  input wire mode_cw_pkg::mc_event_t mc_event,
  output mode_cw_pkg::mc_resp_t mc_resp,
  output mode_cw_pkg::irq_out_t irq_out
);
  typedef struct packed {
    logic mr_meta;
    logic mr_sync;
    logic [15:0] rdata;
    logic busy;
    logic [5:0] cur_index;
    logic irq;
    logic log_we;
    logic [5:0] log_index;
    mode_cw_pkg::mc_resp_t resp;
  } state_t;

  state_t state_reg;
  state_t state_next;
  logic [5:0] ram_raddr;
  logic [15:0] ram_rdata;
  logic ram_we;
  logic [5:0] ram_waddr;
  logic [15:0] ram_wdata;
  logic bcast_valid;
  logic clear_all;
  logic [5:0] ev_index;

  function automatic logic [5:0] cw_index(input logic transmit, input logic [4:0] mc);
    cw_index = {transmit, mc};
  endfunction

  // The master reset pin is asynchronous to mclk, so it is synchronised first.
  assign clear_all = !state_reg.mr_sync || software_reset_cmd;
  assign bcast_valid = (mc_event.rt_addr == mode_cw_pkg::BCAST_ADDR) && !broadcast_disable;
  assign ev_index = cw_index(mc_event.transmit, mc_event.mode_code);

  cw_store #(
    .DEPTH(mode_cw_pkg::CW_COUNT),
    .AW(mode_cw_pkg::CW_AW)
  ) u_store (
    .mclk(mclk),
    .reset_n(reset_n),
    .clear_all(clear_all),
    .raddr(ram_raddr),
    .rdata(ram_rdata),
    .we(ram_we),
    .waddr(ram_waddr),
    .wdata(ram_wdata)
  );

  always_comb
  begin
    logic [15:0] cw;
    logic ok_cmd;
    logic toggle;
    cw = ram_rdata;
    ok_cmd = 1'b0;
    toggle = 1'b0;
    state_next = state_reg;
    state_next.mr_meta = master_reset_n;
    state_next.mr_sync = state_reg.mr_meta;
    state_next.irq = 1'b0;
    state_next.log_we = 1'b0;
    ram_raddr = host_addr;
    ram_we = 1'b0;
    ram_waddr = host_addr;
    ram_wdata = ram_rdata;
    // Device events own the memory port; host access waits no cycle but yields.
    if (mc_event.start)
    begin
      ram_raddr = ev_index;
      state_next.cur_index = ev_index;
      state_next.busy = cw[mode_cw_pkg::BIT_FORCE_BUSY]
        && (mc_event.mode_code != mode_cw_pkg::MC_RESET_RT);
      state_next.resp.busy = state_next.busy;
      state_next.resp.send_data = !state_next.busy
        && (mc_event.mode_code >= mode_cw_pkg::MC_DATA_FIRST);
      state_next.resp.pingpong = cw[mode_cw_pkg::BIT_PP_ENABLE] && cw[mode_cw_pkg::BIT_PP_ACK];
      state_next.resp.use_second = cw[mode_cw_pkg::BIT_PTR_SECOND];
    end
    else if (mc_event.done)
    begin
      ram_raddr = state_reg.cur_index;
      ok_cmd = !mc_event.illegal && (mc_event.rt_addr != mode_cw_pkg::BCAST_ADDR || bcast_valid);
      cw[mode_cw_pkg::BIT_ACCESSED] = 1'b1;
      // No stop request exists here, so the acknowledge follows the enable.
      // The first command after enabling therefore still runs single-buffer.
      cw[mode_cw_pkg::BIT_PP_ACK] = cw[mode_cw_pkg::BIT_PP_ENABLE];
      toggle = state_reg.resp.pingpong && mc_event.good && !state_reg.busy;
      if (pointer_toggle_hold_on_fail && (mc_event.illegal || mc_event.busy_end))
      begin
        toggle = 1'b0;
      end
      if (toggle)
      begin
        cw[mode_cw_pkg::BIT_PTR_SECOND] = !cw[mode_cw_pkg::BIT_PTR_SECOND];
      end
      ram_we = 1'b1;
      ram_waddr = state_reg.cur_index;
      ram_wdata = cw;
      if (ok_cmd && bcast_valid && mc_event.transmit && broadcast_irq_enable
          && cw[mode_cw_pkg::BIT_IRQ_REQ])
      begin
        state_next.irq = 1'b1;
        state_next.log_we = 1'b1;
        state_next.log_index = state_reg.cur_index;
      end
    end
    else if (host_wr)
    begin
      ram_we = 1'b1;
      ram_wdata = (ram_rdata & ~mode_cw_pkg::HOST_WMASK) | (host_wdata & mode_cw_pkg::HOST_WMASK);
    end
    else if (host_rd)
    begin
      state_next.rdata = ram_rdata;
      ram_we = 1'b1;
      ram_wdata = ram_rdata;
      ram_wdata[mode_cw_pkg::BIT_ACCESSED] = 1'b0;
    end
    if (clear_all)
    begin
      state_next.busy = 1'b0;
      state_next.resp = '0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!reset_n)
    begin
      state_reg <= '{mr_meta: 1'b1, mr_sync: 1'b1, default: '0};
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign host_rdata = state_reg.rdata;
  assign mc_resp = state_reg.resp;
  assign irq_out.irq = state_reg.irq;
  assign irq_out.log_we = state_reg.log_we;
  assign irq_out.log_index = state_reg.log_index;

  a_reset_busy_inhibit : assert property (@(posedge mclk) disable iff (!reset_n)
    mc_event.start && mc_event.mode_code == mode_cw_pkg::MC_RESET_RT && !clear_all
    |=> !mc_resp.busy) else $error("busy set for reset terminal");
  a_busy_no_data : assert property (@(posedge mclk) disable iff (!reset_n)
    mc_resp.busy |-> !mc_resp.send_data) else $error("data sent while busy");
  a_irq_needs_enable : assert property (@(posedge mclk) disable iff (!reset_n)
    irq_out.irq |-> $past(broadcast_irq_enable) && !$past(broadcast_disable))
    else $error("interrupt without enable");
  a_irq_log_pair : assert property (@(posedge mclk) disable iff (!reset_n)
    irq_out.irq == irq_out.log_we) else $error("interrupt not logged");
  a_irq_after_done : assert property (@(posedge mclk) disable iff (!reset_n)
    irq_out.irq |-> $past(mc_event.done)) else $error("interrupt without completion");
  a_disable_blocks_irq : assert property (@(posedge mclk) disable iff (!reset_n)
    broadcast_disable ##1 broadcast_disable |-> !irq_out.irq)
    else $error("interrupt with broadcast disabled");
  a_reset_clears_resp : assert property (@(posedge mclk) disable iff (!reset_n)
    software_reset_cmd |=> mc_resp == '0) else $error("reset left response");
  a_busy_force : assert property (@(posedge mclk) disable iff (!reset_n)
    mc_event.start && !clear_all && ram_rdata[mode_cw_pkg::BIT_FORCE_BUSY]
    && mc_event.mode_code != mode_cw_pkg::MC_RESET_RT |=> mc_resp.busy)
    else $error("force busy ignored");
  a_done_sets_flag : assert property (@(posedge mclk) disable iff (!reset_n)
    mc_event.done && !mc_event.start |-> ram_we && ram_wdata[mode_cw_pkg::BIT_ACCESSED])
    else $error("accessed flag not set on completion");
  a_read_clears_flag : assert property (@(posedge mclk) disable iff (!reset_n)
    host_rd && !host_wr && !mc_event.start && !mc_event.done
    |-> ram_we && !ram_wdata[mode_cw_pkg::BIT_ACCESSED])
    else $error("accessed flag not cleared on read");
  a_busy_keeps_ptr : assert property (@(posedge mclk) disable iff (!reset_n)
    mc_event.done && !mc_event.start && state_reg.busy
    |-> ram_wdata[mode_cw_pkg::BIT_PTR_SECOND] == ram_rdata[mode_cw_pkg::BIT_PTR_SECOND])
    else $error("pointer toggled after busy message");
endmodule

//--- dv/bc_model.sv
// Bus controller model: issues one mode command for each go pulse.
// Assumes go is raised only while idle is high; gap sets the command length.
module bc_model (
  input wire logic mclk,
  input wire logic go,
  input wire mode_cw_pkg::mc_event_t cmd,
  input wire logic [3:0] gap,
  output mode_cw_pkg::mc_event_t mc_event,
  output logic idle
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    mc_event = '0;
    idle = 1'b1;
    forever
    begin
      @(posedge mclk);
      if (go)
      begin
        idle <= 1'b0;
        mc_event <= cmd;
        mc_event.start <= 1'b1;
        @(posedge mclk);
        mc_event.start <= 1'b0;
        repeat (gap) @(posedge mclk);
        mc_event.done <= 1'b1;
        @(posedge mclk);
        // Idle fields are scrambled so nothing can lean on stale values.
        mc_event <= ~cmd;
        mc_event.start <= 1'b0;
        mc_event.done <= 1'b0;
        idle <= 1'b1;
      end
    end
  end
endmodule

//--- dv/mode_cw_flags_bench.sv
// Self-checking bench for the mode code Control Word flag block.
// Assumes bc_model as the bus controller and a 100 MHz clock.
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin fails++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module mode_cw_flags_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, reset_n = 0, master_reset_n = 0, software_reset_cmd = 0;
  logic broadcast_irq_enable = 0, broadcast_disable = 0;
  logic pointer_toggle_hold_on_fail = 1;
  logic [5:0] host_addr = 6'h00;
  logic [15:0] host_wdata = 16'h0000, host_rdata;
  logic host_wr = 0, host_rd = 0, go = 0, idle;
  logic [3:0] gap = 4'h0;
  int fails = 0, checked = 0, irqs = 0, logs = 0;
  mode_cw_pkg::mc_event_t cmd = '0, mc_event;
  mode_cw_pkg::mc_resp_t mc_resp;
  mode_cw_pkg::irq_out_t irq_out;
  mode_cw_flags dut (.mclk(mclk), .reset_n(reset_n), .master_reset_n(master_reset_n),
    .software_reset_cmd(software_reset_cmd), .broadcast_irq_enable(broadcast_irq_enable),
    .broadcast_disable(broadcast_disable),
    .pointer_toggle_hold_on_fail(pointer_toggle_hold_on_fail), .host_addr(host_addr),
    .host_wdata(host_wdata), .host_wr(host_wr), .host_rd(host_rd), .host_rdata(host_rdata),
    .mc_event(mc_event), .mc_resp(mc_resp), .irq_out(irq_out));
  bc_model bc (.mclk(mclk), .go(go), .cmd(cmd), .gap(gap), .mc_event(mc_event), .idle(idle));
  initial forever #5 mclk = ~mclk;
  always @(posedge mclk)
  begin
    if (irq_out.irq === 1'b1) irqs++;
    if (irq_out.log_we === 1'b1) logs++;
  end
  task automatic hw(input logic [5:0] a, input logic [15:0] d);
    @(posedge mclk);
    host_addr <= a;
    host_wdata <= d;
    host_wr <= 1'b1;
    @(posedge mclk);
    host_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [5:0] a, input logic [15:0] e);
    @(posedge mclk);
    host_addr <= a;
    host_rd <= 1'b1;
    @(posedge mclk);
    host_rd <= 1'b0;
    #1;
    `CHK("host_rdata", e, host_rdata)
  endtask
  task automatic issue(input logic [4:0] a, input logic [4:0] m, input logic b);
    int n;
    @(posedge mclk);
    cmd <= '{1'b0, 1'b0, 1'b1, b, 1'b0, 1'b1, a, m};
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (!idle && n < 40);
    if (n >= 40) fails++;
    repeat (2) @(posedge mclk);
  endtask
  task automatic t_busy();
    hw(6'h30, 16'hffff);
    rchk(6'h30, mode_cw_pkg::HOST_WMASK);
    hw(6'h30, 16'h1000);
    issue(5'h05, 5'h10, 1'b1);
    `CHK("busy", 1'b1, mc_resp.busy)
    `CHK("send_data", 1'b0, mc_resp.send_data)
    rchk(6'h30, 16'h1800);
    rchk(6'h30, 16'h1000);
    hw(6'h30, 16'h0004);
    gap <= 4'h3;
    issue(5'h05, 5'h10, 1'b0);
    `CHK("busy", 1'b0, mc_resp.busy)
    `CHK("send_data", 1'b1, mc_resp.send_data)
    `CHK("pingpong", 1'b0, mc_resp.pingpong)
    rchk(6'h30, 16'h0904);
    issue(5'h05, 5'h10, 1'b0);
    `CHK("pingpong", 1'b1, mc_resp.pingpong)
    `CHK("use_second", 1'b0, mc_resp.use_second)
    issue(5'h05, 5'h10, 1'b0);
    `CHK("use_second", 1'b1, mc_resp.use_second)
    rchk(6'h30, 16'h0904);
    hw(6'h28, 16'h1000);
    issue(5'h05, 5'h08, 1'b0);
    `CHK("busy", 1'b0, mc_resp.busy)
    $display("test busy finished");
  endtask
  task automatic t_irq();
    hw(6'h21, 16'h2000);
    for (int i = 0; i < 4; i++)
    begin
      int bi, bl;
      broadcast_irq_enable <= (i != 3);
      broadcast_disable <= (i == 1);
      bi = irqs;
      bl = logs;
      issue((i == 2) ? 5'h05 : 5'h1f, 5'h01, 1'b0);
      `CHK("irq", (i == 0) ? 1 : 0, irqs - bi)
      `CHK("log_we", (i == 0) ? 1 : 0, logs - bl)
    end
    `CHK("log_index", 6'h21, irq_out.log_index)
    $display("test irq finished");
  endtask
  task automatic t_resets();
    software_reset_cmd <= 1'b1;
    @(posedge mclk);
    software_reset_cmd <= 1'b0;
    rchk(6'h21, 16'h0000);
    hw(6'h30, 16'h3004);
    master_reset_n <= 1'b0;
    repeat (4) @(posedge mclk);
    master_reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(6'h30, 16'h0000);
    $display("test resets finished");
  endtask
  task automatic stop_test();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    master_reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    rchk(6'h30, 16'h0000);
    t_busy();
    t_irq();
    t_resets();
    stop_test();
  end
  initial
  begin
    #100000;
    fails++;
    stop_test();
  end
endmodule
